// ---- inc/tws_defines.svh ----
`ifndef TWS_DEFINES_SVH
`define TWS_DEFINES_SVH
// Behaviour
// - Sample data on clock rise, drive after fall.
// - Protect input high blocks every array write.
// - Eleven-bit address: row byte plus segment bits.
// - Writes finish inside the transfer, no polling.
// - Data rising while clock high stops everything.
// - Data falling while clock high restarts addressing.
// - Receiver pulls data low in ninth clock.
// - Missing acknowledge ends operation, await addressing.
// - Read continues while master acknowledges and clocks.
// - First byte is address; type must be 1010b.
// - Address bits 3-1 select the 256-byte page.
// - Address bit 0 high reads, low writes.
// - Write takes word address, latches full address.
// - Read uses page plus latched low byte.
// - Address increments per byte, wraps to zero.
// - No limit on bytes per operation.
// - Slave only; never drives the serial clock.
// - Only a power-on reset initialises the interface.
// - Protected data bytes get no acknowledge, no increment.
// - Byte commits only after its eighth bit.
// - Random read: write address, restart, then read.
// - All bytes travel most significant bit first.

// Device-type pattern in the upper nibble of the slave address.
`define TWS_DEV_TYPE 4'hA
// Field positions inside the slave address byte.
`define TWS_TYPE_HI 7
`define TWS_TYPE_LO 4
`define TWS_PAGE_HI 3
`define TWS_PAGE_LO 1
`define TWS_RW_BIT 0
// Bit counter value of the last data bit and of the acknowledge slot.
`define TWS_LAST_BIT 4'h7
`define TWS_ACK_BIT 4'h8
// Reset levels of the pins as seen after the synchronisers.
`define TWS_SCL_RST 1'b1
`define TWS_SDA_RST 1'b1
`define TWS_WP_RST 1'b0
`endif

// ---- inc/tws_pkg.sv ----
package tws_pkg;
  // Protocol engine states, one-hot.
  typedef enum logic [5:0] {
    TWS_IDLE = 6'h01,
    TWS_DEV = 6'h02,
    TWS_WORD = 6'h04,
    TWS_WR = 6'h08,
    TWS_RD = 6'h10,
    TWS_IGN = 6'h20
  } tws_state_t;
  // Location address and data byte types.
  typedef logic [10:0] tws_addr_t;
  typedef logic [7:0] tws_byte_t;
endpackage

// ---- rtl/tws_sync.sv ----
`timescale 1ns/1ps
// Three-stage pin synchroniser with a two-sample agreement filter.
module tws_sync #(
  parameter logic RST = 1'b0
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic pin,
  output logic level
);
  logic s1_q; // First stage, read only by the second.
  logic s2_q; // Second stage.
  logic s3_q; // Third stage.
  logic level_q; // Filtered level.

  // The level only moves once the second and third stages agree, which
  // swallows a one-cycle glitch at the cost of one more cycle of delay.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      s1_q <= RST;
      s2_q <= RST;
      s3_q <= RST;
      level_q <= RST;
    end else begin
      s1_q <= pin;
      s2_q <= s1_q;
      s3_q <= s2_q;
      level_q <= (s2_q == s3_q) ? s3_q : level_q;
    end
  end

  assign level = level_q;
endmodule

// ---- rtl/tws_link.sv ----
`timescale 1ns/1ps
// Receive shifter that lives on the serial clock itself.
module tws_link (
  input wire logic scl,
  input wire logic reset_n,
  input wire logic sda_i,
  output logic [7:0] rx_shift
);
  logic [7:0] shift_q; // Last eight bits seen on the data line.

  // Every rising serial edge takes one bit, most significant first, so
  // after the eighth edge the byte sits in natural order. The word is
  // read by the system-clock side only after it has seen that edge
  // through its synchroniser, and it then stays still for at least
  // half a serial period, so the read is safe without a handshake.
  always_ff @(posedge scl or negedge reset_n) begin
    if (!reset_n) begin
      shift_q <= 8'h00;
    end else begin
      shift_q <= {shift_q[6:0], sda_i};
    end
  end

  assign rx_shift = shift_q;
endmodule

// ---- rtl/tws_slave.sv ----
`timescale 1ns/1ps
`include "tws_defines.svh"
// Two-wire slave front end of a 2,048-byte nonvolatile byte memory.
module tws_slave
  import tws_pkg::*;
(
  input wire logic clk,
  input wire logic reset_n,
  input wire logic scl,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe,
  input wire logic wp,
  output tws_addr_t mem_addr,
  output tws_byte_t mem_wdata,
  output logic mem_we,
  output logic mem_re,
  input wire tws_byte_t mem_rdata
);

  // Synchronised pin levels.
  logic scl_s; // Serial clock as a level in the system domain.
  logic sda_s; // Data line as a level in the system domain.
  logic wp_s; // Protect input; the board pull-down keeps it low.
  tws_byte_t rx_shift; // Byte shifter from the serial-clock domain.

  // Registered state.
  tws_state_t state_q, state_d; // Protocol engine state.
  logic [3:0] bit_cnt_q, bit_cnt_d; // Rising edges seen in this byte.
  logic scl_prev_q; // Previous serial clock level.
  logic sda_prev_q; // Previous data level.
  logic ack_pend_q, ack_pend_d; // Pull the line low in the next slot.
  logic oe_q, oe_d; // Open-drain pull-down enable.
  tws_byte_t tx_q, tx_d; // Remaining bits of the byte being read.
  tws_addr_t addr_q, addr_d; // Location address latch.
  logic [2:0] page_q, page_d; // Page select from the last address.
  tws_byte_t wdata_q; // Byte handed to the array.
  logic we_q; // One-cycle array write strobe.
  logic re_q; // One-cycle array read strobe.
  logic sda_o_q; // Driven level; always low for an open drain.

  // Address plus one; the 11-bit width makes 7FFh roll over to 000h.
  function automatic tws_addr_t addr_next(input tws_addr_t a);
    addr_next = a + 11'h001;
  endfunction

  tws_sync #(.RST(`TWS_SCL_RST)) u_sync_scl (
    .clk(clk),
    .reset_n(reset_n),
    .pin(scl),
    .level(scl_s)
  );

  tws_sync #(.RST(`TWS_SDA_RST)) u_sync_sda (
    .clk(clk),
    .reset_n(reset_n),
    .pin(sda_i),
    .level(sda_s)
  );

  tws_sync #(.RST(`TWS_WP_RST)) u_sync_wp (
    .clk(clk),
    .reset_n(reset_n),
    .pin(wp),
    .level(wp_s)
  );

  // The serial clock is only ever an input here; nothing drives it.
  tws_link u_link (
    .scl(scl),
    .reset_n(reset_n),
    .sda_i(sda_i),
    .rx_shift(rx_shift)
  );

  // Edge and condition decoding on the synchronised levels. Both pins
  // pass identical delay, so a data change that follows a clock fall
  // is seen in the same order. A master that moves data in the very
  // same instant as the clock edge may still be misread.
  wire scl_rise = scl_s & ~scl_prev_q;
  wire scl_fall = ~scl_s & scl_prev_q;
  wire scl_high = scl_s & scl_prev_q;
  wire start_det = scl_high & sda_prev_q & ~sda_s;
  wire stop_det = scl_high & ~sda_prev_q & sda_s;
  wire byte_done = scl_rise & (bit_cnt_q == `TWS_LAST_BIT);
  wire ack_rise = scl_rise & (bit_cnt_q == `TWS_ACK_BIT);
  wire type_ok = rx_shift[`TWS_TYPE_HI:`TWS_TYPE_LO] == `TWS_DEV_TYPE;
  wire rw_read = rx_shift[`TWS_RW_BIT];
  wire [2:0] page_sel = rx_shift[`TWS_PAGE_HI:`TWS_PAGE_LO];
  wire in_dev = state_q == TWS_DEV;
  wire in_word = state_q == TWS_WORD;
  wire in_wr = state_q == TWS_WR;
  wire in_rd = state_q == TWS_RD;
  wire dev_read = byte_done & in_dev & type_ok & rw_read;
  wire wr_commit = byte_done & in_wr & ~wp_s;
  wire rd_load = scl_fall & in_rd & (bit_cnt_q == 4'h0);
  wire rd_shift = scl_fall & in_rd & (bit_cnt_q != 4'h0) &
                  (bit_cnt_q != `TWS_ACK_BIT);

  // Next state. A start wins over everything, then a stop; the byte
  // decode only acts on the eighth rising edge of a byte.
  always_comb begin
    state_d = state_q;
    if (start_det) begin
      state_d = TWS_DEV;
    end else if (stop_det) begin
      state_d = TWS_IDLE;
    end else if (byte_done) begin
      unique case (state_q)
        TWS_DEV: begin
          if (!type_ok) begin
            state_d = TWS_IGN;
          end else if (rw_read) begin
            state_d = TWS_RD;
          end else begin
            state_d = TWS_WORD;
          end
        end
        TWS_WORD: state_d = TWS_WR;
        TWS_WR: state_d = wp_s ? TWS_IGN : TWS_WR;
        TWS_RD: state_d = TWS_RD;
        TWS_IDLE: state_d = TWS_IDLE;
        TWS_IGN: state_d = TWS_IGN;
      endcase
    end else if (ack_rise & in_rd & sda_s) begin
      state_d = TWS_IGN;
    end
  end

  // Bit counter: nine rising edges per byte, the ninth is the slot.
  assign bit_cnt_d = (start_det | stop_det) ? 4'h0 :
                     !scl_rise ? bit_cnt_q :
                     (bit_cnt_q == `TWS_ACK_BIT) ? 4'h0 :
                     bit_cnt_q + 4'h1;

  // Whether this device pulls the coming acknowledge slot low. A read
  // byte is acknowledged by the master, so it never sets this.
  assign ack_pend_d = (start_det | stop_det) ? 1'b0 :
                      !byte_done ? ack_pend_q :
                      in_dev ? type_ok :
                      in_word ? 1'b1 :
                      in_wr ? ~wp_s :
                      1'b0;

  // Page select is captured from every matching slave address.
  assign page_d = (byte_done & in_dev & type_ok) ? page_sel : page_q;

  // Address latch. Writes step the address in the cycle after the
  // strobe so the array sees the strobe with the old address; reads
  // step at the eighth bit. Both land well before the slot.
  always_comb begin
    addr_d = addr_q;
    if (dev_read) begin
      addr_d = {page_sel, addr_q[7:0]};
    end else if (byte_done & in_word) begin
      addr_d = {page_q, rx_shift};
    end else if (byte_done & in_rd) begin
      addr_d = addr_next(addr_q);
    end else if (we_q) begin
      addr_d = addr_next(addr_q);
    end
  end

  // Read data shifter, loaded at the fall that opens each read byte.
  assign tx_d = rd_load ? {mem_rdata[6:0], 1'b0} :
                rd_shift ? {tx_q[6:0], 1'b0} :
                tx_q;

  // Pull-down enable. It only moves on a serial clock fall so the line
  // is stable again before the next rise; start and stop release it.
  assign oe_d = (start_det | stop_det) ? 1'b0 :
                !scl_fall ? oe_q :
                (bit_cnt_q == `TWS_ACK_BIT) ? ack_pend_q :
                rd_load ? ~mem_rdata[7] :
                rd_shift ? ~tx_q[7] :
                1'b0;

  // Engine state and pin history.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state_q <= TWS_IDLE;
      bit_cnt_q <= 4'h0;
      scl_prev_q <= `TWS_SCL_RST;
      sda_prev_q <= `TWS_SDA_RST;
      ack_pend_q <= 1'b0;
    end else begin
      state_q <= state_d;
      bit_cnt_q <= bit_cnt_d;
      scl_prev_q <= scl_s;
      sda_prev_q <= sda_s;
      ack_pend_q <= ack_pend_d;
    end
  end

  // Data path and pin drive.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      oe_q <= 1'b0;
      sda_o_q <= 1'b0;
      tx_q <= 8'h00;
      addr_q <= 11'h000;
      page_q <= 3'h0;
    end else begin
      oe_q <= oe_d;
      sda_o_q <= 1'b0;
      tx_q <= tx_d;
      addr_q <= addr_d;
      page_q <= page_d;
    end
  end

  // Array strobes. The write happens at bus speed with no busy time, so
  // a following operation may start at once. A start or stop before
  // the eighth bit never reaches this point, so memory is untouched.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      we_q <= 1'b0;
      re_q <= 1'b0;
      wdata_q <= 8'h00;
    end else begin
      we_q <= wr_commit;
      re_q <= dev_read | (byte_done & in_rd);
      wdata_q <= wr_commit ? rx_shift : wdata_q;
    end
  end

  assign sda_o = sda_o_q;
  assign sda_oe = oe_q;
  assign mem_addr = addr_q;
  assign mem_wdata = wdata_q;
  assign mem_we = we_q;
  assign mem_re = re_q;

  // Checks on the engine.
  a_start_rearm: assert property (@(posedge clk) disable iff (!reset_n)
    start_det |=> state_q == TWS_DEV && bit_cnt_q == 4'h0 && !sda_oe)
    else $error("start did not rearm addressing");

  a_stop_abort: assert property (@(posedge clk) disable iff (!reset_n)
    stop_det |=> state_q == TWS_IDLE && !sda_oe && !mem_we)
    else $error("stop did not abort the operation");

  a_type_ignore: assert property (@(posedge clk) disable iff (!reset_n)
    byte_done && in_dev && !type_ok |=> state_q == TWS_IGN [*3] ##0 !sda_oe)
    else $error("foreign type address was not ignored");

  a_protect_block: assert property (@(posedge clk) disable iff (!reset_n)
    byte_done && in_wr && wp_s |=> !mem_we && !ack_pend_q ##1 $stable(mem_addr))
    else $error("protected byte was written or acknowledged");

  a_write_commit: assert property (@(posedge clk) disable iff (!reset_n)
    byte_done && in_wr && !wp_s |=> mem_we && mem_wdata == $past(rx_shift))
    else $error("write byte not committed after eighth bit");

  a_addr_step: assert property (@(posedge clk) disable iff (!reset_n)
    mem_we |=> mem_addr == addr_next($past(mem_addr)))
    else $error("address did not step after a write");

  a_word_latch: assert property (@(posedge clk) disable iff (!reset_n)
    byte_done && in_word |=> mem_addr == {$past(page_q), $past(rx_shift)})
    else $error("word address not latched with page");

  a_read_page: assert property (@(posedge clk) disable iff (!reset_n)
    dev_read |=> mem_addr[10:8] == $past(page_sel) && mem_re
      && mem_addr[7:0] == $past(addr_q[7:0]))
    else $error("read address not formed from page and latch");

  a_ack_drive: assert property (@(posedge clk) disable iff (!reset_n)
    scl_fall && bit_cnt_q == `TWS_ACK_BIT && ack_pend_q && !start_det
      |=> sda_oe)
    else $error("acknowledge slot not driven low");

  a_read_nack: assert property (@(posedge clk) disable iff (!reset_n)
    ack_rise && in_rd && sda_s && !start_det && !stop_det
      |=> state_q == TWS_IGN ##1 !sda_oe)
    else $error("not-acknowledge did not end the read");

  a_drive_on_fall: assert property (@(posedge clk) disable iff (!reset_n)
    $rose(sda_oe) |-> $past(scl_fall))
    else $error("data line driven outside a clock fall");

  c_write_byte: cover property (@(posedge clk) disable iff (!reset_n)
    wr_commit);
  c_read_more: cover property (@(posedge clk) disable iff (!reset_n)
    ack_rise && in_rd && !sda_s);
  c_read_end: cover property (@(posedge clk) disable iff (!reset_n)
    ack_rise && in_rd && sda_s);
  c_restart_write: cover property (@(posedge clk) disable iff (!reset_n)
    start_det && in_wr);
endmodule

// ---- bench/tws_master.sv ----
`timescale 1ns/1ps
// Behavioural two-wire bus master; it alone makes the serial clock.
module tws_master (
  output logic scl,
  output logic sda_m,
  input wire logic sda
);
  // A quarter of the 125 ns serial clock period.
  localparam realtime QTR = 31.25;
  // Both lines start released; the clock stands still high between frames.
  initial begin
    scl = 1'b1;
    sda_m = 1'b1;
  end
  // One bit: data moves only in mid-low, and the wire is sampled at the rise.
  task automatic bit_x(input logic b, output logic r);
    #QTR sda_m <= b;
    #QTR scl <= 1'b1;
    r = sda;
    #(2*QTR) scl <= 1'b0;
  endtask
  // Data falls while the clock is high; it also serves as a repeated start.
  task automatic start();
    #(2*QTR) sda_m <= 1'b1;
    #(2*QTR) scl <= 1'b1;
    #(2*QTR) sda_m <= 1'b0;
    #(2*QTR) scl <= 1'b0;
  endtask
  // Data rises while the clock is high; only called while this side owns data.
  task automatic stop();
    #QTR sda_m <= 1'b0;
    #QTR scl <= 1'b1;
    #(2*QTR) sda_m <= 1'b1;
  endtask
  // Sends a byte high bit first and releases the line for the acknowledge.
  task automatic wr_byte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bit_x(d[i], r);
    bit_x(1'b1, r);
    ack = ~r;
  endtask
  // Reads a byte and answers it; the last wanted byte goes unanswered.
  task automatic rd_byte(input logic ack, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_x(1'b1, r);
      d[i] = r;
    end
    bit_x(~ack, r);
  endtask
endmodule

// ---- bench/two_wire_slave_byte_memory_tb.sv ----
`timescale 1ns/1ps
// Self-checking bench: a master model on the link and an array model behind.
module two_wire_slave_byte_memory_tb import tws_pkg::*;;
  logic clk;
  logic reset_n;
  logic wp;
  logic scl;
  logic sda_m;
  logic sda_o;
  logic sda_oe;
  logic mem_we;
  logic mem_re; // Read strobe from the device, counted below.
  tws_addr_t mem_addr;
  tws_byte_t mem_wdata;
  tws_byte_t mem_rdata;
  tws_byte_t mem [0:2047];
  wire logic sda_i;
  int n_errors = 0;
  int checked = 0;
  int cycles = 0;
  int n_reads = 0; // Array read strobes seen so far.
  // The wire has a pull-up; whoever pulls low wins.
  assign sda_i = sda_m & ~(sda_oe & ~sda_o);
  assign mem_rdata = mem[mem_addr];
  tws_slave i_dut (
    .clk(clk), .reset_n(reset_n), .scl(scl), .sda_i(sda_i), .sda_o(sda_o),
    .sda_oe(sda_oe), .wp(wp), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
    .mem_we(mem_we), .mem_re(mem_re), .mem_rdata(mem_rdata)
  );
  tws_master i_mst (.scl(scl), .sda_m(sda_m), .sda(sda_i));
  // A pattern that differs across pages, so a wrong page shows up.
  function automatic tws_byte_t pat(input tws_addr_t a);
    return a[7:0] ^ {5'h00, a[10:8]} ^ 8'h5A;
  endfunction
  // The array starts filled with the pattern and takes each write strobe.
  initial for (int i = 0; i < 2048; i++) mem[i] = pat(tws_addr_t'(i));
  always @(posedge clk) if (mem_we) mem[mem_addr] <= mem_wdata;
  // Each read strobe is one fetch; a refused byte must not cost one.
  always @(posedge clk) if (mem_re) n_reads++;
  // The system clock at 100 MHz.
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // The whole run needs about 3500 cycles; nearly six times that means a hang.
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      n_errors++;
      finish_test();
    end
  end
  // Compares a seen value with an expected one and counts both outcomes.
  task automatic check(input tws_byte_t seen, input tws_byte_t exp);
    checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("wrong value at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask
  // Prints the counts and the verdict, then ends the run.
  task automatic finish_test();
    $display("checks %0d errors %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // Starts a frame with a slave address and judges its acknowledge.
  task automatic open(input logic [3:0] kind, input logic [2:0] pg, input logic rw,
                      input logic ok);
    logic a;
    i_mst.start();
    i_mst.wr_byte({kind, pg, rw}, a);
    check(8'(a), 8'(ok));
  endtask
  // Sends one byte and judges its acknowledge.
  task automatic send(input tws_byte_t d, input logic ok);
    logic a;
    i_mst.wr_byte(d, a);
    check(8'(a), 8'(ok));
  endtask
  // Reads one byte and expects the untouched pattern of a location.
  task automatic recv(input logic ack, input tws_addr_t at);
    tws_byte_t d;
    i_mst.rd_byte(ack, d);
    check(d, pat(at));
  endtask
  // Burst write across the top of the array, which must wrap to zero.
  task automatic t_write();
    open(4'hA, 3'h7, 1'b0, 1'b1);
    send(8'hFE, 1'b1);
    send(8'h11, 1'b1);
    send(8'h22, 1'b1);
    send(8'h33, 1'b1);
    i_mst.stop();
    check(mem[11'h7FE], 8'h11);
    check(mem[11'h7FF], 8'h22);
    check(mem[11'h000], 8'h33);
  endtask
  // Random read; after the final refusal the device must let the line go.
  task automatic t_rand_read();
    tws_byte_t d;
    int base;
    base = n_reads;
    open(4'hA, 3'h2, 1'b0, 1'b1);
    send(8'h10, 1'b1);
    open(4'hA, 3'h2, 1'b1, 1'b1);
    recv(1'b1, 11'h210);
    recv(1'b1, 11'h211);
    recv(1'b0, 11'h212);
    i_mst.rd_byte(1'b0, d);
    check(d, 8'hFF);
    i_mst.stop();
    // One fetch for the read address and one per byte until the refusal.
    check(8'(n_reads - base), 8'h04);
  endtask
  // Current read: a new page joined to the low byte just past the last access.
  task automatic t_cur_read();
    tws_byte_t d;
    open(4'hA, 3'h3, 1'b1, 1'b1);
    i_mst.rd_byte(1'b0, d);
    check(d, pat(11'h313));
    i_mst.stop();
  endtask
  // A foreign device type gets no acknowledge and no data.
  task automatic t_foreign();
    tws_byte_t d;
    open(4'h5, 3'h2, 1'b1, 1'b0);
    i_mst.rd_byte(1'b0, d);
    check(d, 8'hFF);
    i_mst.stop();
  endtask
  // Protected write: refused, memory kept, and the address does not step.
  task automatic t_protect();
    @(posedge clk) wp <= 1'b1;
    open(4'hA, 3'h1, 1'b0, 1'b1);
    send(8'h40, 1'b1);
    send(8'h77, 1'b0);
    check(mem[11'h140], pat(11'h140));
    i_mst.stop();
    @(posedge clk) wp <= 1'b0;
    open(4'hA, 3'h1, 1'b1, 1'b1);
    recv(1'b0, 11'h140);
    i_mst.stop();
  endtask
  // Bytes cut short by a stop or a start never reach the array.
  task automatic t_abort();
    logic r;
    open(4'hA, 3'h0, 1'b0, 1'b1);
    send(8'h80, 1'b1);
    repeat (4) i_mst.bit_x(1'b0, r);
    i_mst.stop();
    check(mem[11'h080], pat(11'h080));
    open(4'hA, 3'h0, 1'b0, 1'b1);
    send(8'h90, 1'b1);
    repeat (3) i_mst.bit_x(1'b1, r);
    open(4'hA, 3'h0, 1'b1, 1'b1);
    recv(1'b0, 11'h090);
    i_mst.stop();
    check(mem[11'h090], pat(11'h090));
  endtask
  // Reset, a quiet bus, then every scenario back to back with no polling.
  initial begin
    reset_n = 1'b0;
    wp = 1'b0;
    repeat (6) @(posedge clk);
    reset_n <= 1'b1;
    repeat (8) @(posedge clk);
    check(8'(sda_oe), 8'h00);
    t_write();
    t_rand_read();
    t_cur_read();
    t_foreign();
    t_protect();
    t_abort();
    finish_test();
  end
endmodule
